/* rtl/lswdt_top.sv */
// lock-and-service watchdog: registers, lock, down counter and timeout action
// assumes oscTick pulses once per low-frequency oscillator period, synchronous to clk_sys
`timescale 1ns/100ps
module lswdt_top
  import lswdt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic oscTick,
  input wire logic shutdown,
  input wire logic wakeFromShutdown,
  input wire logic hibernate,
  input wire logic activeMode,
  input wire logic [lswdt_pkg::ADDR_W-1:0] regAddr,
  input wire logic [lswdt_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [lswdt_pkg::DATA_W-1:0] regRdata,
  output logic resetReq,
  output logic irqReq
);
  import lswdt_pkg::*;

  logic [DATA_W-1:0] control;
  logic [DATA_W-1:0] reloadValue;
  logic [DATA_W-1:0] counter;
  logic [DATA_W-1:0] countShadow;
  logic [DATA_W-1:0] next_rdata;
  logic locked;
  logic irqPending;
  logic wrControl;
  logic wrReload;
  logic wrService;
  logic keyGood;
  logic acceptCfg;
  logic conBusy;
  logic ldBusy;
  logic svcBusy;
  logic conLanded;
  logic ldLanded;
  logic svcLanded;
  logic svcGoodPend;
  logic prescTick;
  logic enabled;
  logic running;
  logic expire;
  logic badKey;
  logic reinit;
  logic enableRise;

  // =========================================
  // write decode
  assign reinit = wakeFromShutdown;
  assign wrControl = regWrite && (regAddr == ADDR_CONTROL);
  assign wrReload = regWrite && (regAddr == ADDR_RELOAD);
  assign wrService = regWrite && (regAddr == ADDR_SERVICE);
  assign keyGood = (regWdata == SERVICE_KEY);
  // locked configuration refuses control and reload writes
  assign acceptCfg = !locked;
  assign enabled = control[CTL_ENABLE];
  // stopped in shutdown, and in hibernate when the halt option is set
  assign running = enabled && !shutdown && !(hibernate && control[CTL_HALT]);
  assign enableRise = wrControl && acceptCfg && regWdata[CTL_ENABLE] && !enabled;

  // =========================================
  // crossing trackers, one per written register
  lswdt_sync u_conSync
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(wrControl && acceptCfg),
    .oscTick(oscTick),
    .busy(conBusy),
    .landed(conLanded)
  );

  lswdt_sync u_ldSync
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(wrReload && acceptCfg),
    .oscTick(oscTick),
    .busy(ldBusy),
    .landed(ldLanded)
  );

  lswdt_sync u_svcSync
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(wrService),
    .oscTick(oscTick),
    .busy(svcBusy),
    .landed(svcLanded)
  );

  // =========================================
  // prescaler, restarted on enable and on a good service
  lswdt_prescaler u_presc
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clear(!running || (wrService && keyGood)),
    .oscTick(oscTick),
    .divSel(control[CTL_PRE_HI:CTL_PRE_LO]),
    .tick(prescTick)
  );

  // =========================================
  // control register and lock
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      control <= RST_CONTROL;
      locked <= 1'b0;
    end
    else if (reinit)
    begin
      control <= RST_CONTROL;
      locked <= 1'b0;
    end
    else if (wrControl && acceptCfg)
    begin
      control <= regWdata & CONTROL_MASK; // writing zero disables
      // only an explicit enable write locks, not the reset default
      locked <= regWdata[CTL_ENABLE];
    end
  end

  // =========================================
  // reload register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      reloadValue <= RST_RELOAD;
    end
    else if (reinit)
    begin
      reloadValue <= RST_RELOAD;
    end
    else if (wrReload && acceptCfg)
    begin
      reloadValue <= regWdata;
    end
  end

  // =========================================
  // down counter; zero is the expiry point
  assign expire = running && prescTick && (counter == 16'h0001 || counter == 16'h0000);
  assign badKey = wrService && !keyGood && enabled;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      counter <= RST_RELOAD;
    end
    else if (reinit)
    begin
      counter <= RST_RELOAD;
    end
    else if (!enabled)
    begin
      counter <= reloadValue; // stopped and reset while disabled
    end
    else if (enableRise || (wrService && keyGood))
    begin
      counter <= reloadValue;
    end
    else if (expire)
    begin
      counter <= reloadValue; // restart after a timeout, in reset or interrupt mode
    end
    else if (running && prescTick)
    begin
      counter <= counter - 16'h0001;
    end
  end

  // =========================================
  // timeout action: reset, or interrupt in active mode when selected
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      resetReq <= 1'b0;
      irqReq <= 1'b0;
    end
    else
    begin
      // interrupt only honoured in active mode, otherwise fall back to reset
      if ((expire || badKey) && (!control[CTL_IRQ] || !activeMode))
        resetReq <= 1'b1;
      else
        resetReq <= 1'b0;
      irqReq <= (expire || badKey) && control[CTL_IRQ] && activeMode;
    end
  end

  // =========================================
  // interrupt pending flag; a new timeout wins over a landing clear
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      irqPending <= 1'b0;
      svcGoodPend <= 1'b0;
    end
    else
    begin
      if (wrService)
        svcGoodPend <= keyGood;
      if ((expire || badKey) && control[CTL_IRQ] && activeMode)
        irqPending <= 1'b1;
      else if (svcLanded && svcGoodPend)
        irqPending <= 1'b0;
    end
  end

  // =========================================
  // count shadow registered into the readable domain
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      countShadow <= RST_RELOAD;
    else
      countShadow <= counter;
  end

  // =========================================
  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = '0;
    case (regAddr)
      ADDR_RELOAD: next_rdata = reloadValue;
      ADDR_COUNT: next_rdata = countShadow;
      ADDR_CONTROL: next_rdata = control;
      ADDR_STATUS:
      begin
        next_rdata = STATUS_FIXED;
        next_rdata[STA_LOCK] = locked;
        next_rdata[STA_CON] = conBusy;
        next_rdata[STA_LD] = ldBusy;
        next_rdata[STA_SVC] = svcBusy;
        next_rdata[STA_IRQ] = irqPending;
      end
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      regRdata <= '0;
    else if (regRead)
      regRdata <= next_rdata;
    else
      regRdata <= '0;
  end

  // landing pulses of control and reload only close their busy windows
  logic unusedLanded;
  assign unusedLanded = conLanded ^ ldLanded;
endmodule

/* rtl/lswdt_pkg.sv */
// constants, register map and field layout of the lock-and-service watchdog
// assumes one 10 MHz system clock; the low-frequency oscillator arrives as a tick enable
// Behaviour
// - a sixteen-bit down counter advanced by prescaled low-frequency oscillator ticks
// - prescaler divides the oscillator by 1, 16, 256 or 4096
// - counter runs while enabled, except during reset, shutdown and hibernate with halt set
// - reset or shutdown wake loads control 0x00E9, reload and count 0x1000
// - control write with enable set locks configuration until reset or shutdown wake
// - status bit 4 shows the configuration lock
// - once enabled count starts at reload value and decrements to zero
// - reaching zero raises reset, or interrupt when selected
// - service key 0xCCCC reloads the counter and restarts the period
// - any other service value triggers the timeout action at once while enabled
// - three busy bits show control, reload and service writes crossing over
// - count register reads a registered copy of the counter, one core clock behind
// - control bit 5 enables; clearing it stops and resets the counter
// - control bits 3:2 select divide 1, 16, 256 or 4096
// - control bit 1 picks interrupt instead of reset, active mode only
// - control bit 0 halts counting in hibernate when set
package lswdt_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD = 32'h40002580;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 32'h40002584;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 32'h40002588;
  localparam logic [ADDR_W-1:0] ADDR_SERVICE = 32'h4000258C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 32'h40002598;
  localparam logic [DATA_W-1:0] RST_CONTROL = 16'h00E9;
  localparam logic [DATA_W-1:0] RST_RELOAD = 16'h1000;
  localparam logic [DATA_W-1:0] STATUS_FIXED = 16'h0020;
  localparam logic [DATA_W-1:0] SERVICE_KEY = 16'hCCCC;
  localparam logic [DATA_W-1:0] CONTROL_MASK = 16'hFFEF;
  localparam int CTL_ENABLE = 5;
  localparam int CTL_PRE_HI = 3;
  localparam int CTL_PRE_LO = 2;
  localparam int CTL_IRQ = 1;
  localparam int CTL_HALT = 0;
  localparam int STA_LOCK = 4;
  localparam int STA_CON = 3;
  localparam int STA_LD = 2;
  localparam int STA_SVC = 1;
  localparam int STA_IRQ = 0;
  localparam int PRE_W = 12;
  // prescale terminal counts (divide minus one)
  localparam logic [PRE_W-1:0] PRE_DIV1 = 12'h000;
  localparam logic [PRE_W-1:0] PRE_DIV16 = 12'h00F;
  localparam logic [PRE_W-1:0] PRE_DIV256 = 12'h0FF;
  localparam logic [PRE_W-1:0] PRE_DIV4096 = 12'hFFF;
  typedef enum logic [2:0]
  {
    SYNC_IDLE = 3'b001,
    SYNC_WAIT = 3'b010,
    SYNC_DONE = 3'b100
  } lswdt_sync_t;
endpackage

/* rtl/lswdt_prescaler.sv */
// prescaler of the low-frequency oscillator tick
// assumes oscTick is a one-cycle enable pulse in the system clock domain
`timescale 1ns/100ps
module lswdt_prescaler
  import lswdt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clear,
  input wire logic oscTick,
  input wire logic [1:0] divSel,
  output logic tick
);
  import lswdt_pkg::*;

  logic [PRE_W-1:0] preCount;
  logic [PRE_W-1:0] terminal;

  // =========================================
  // divide selection
  always_comb
  begin
    case (divSel)
      2'h0: terminal = PRE_DIV1;
      2'h1: terminal = PRE_DIV16;
      2'h2: terminal = PRE_DIV256;
      default: terminal = PRE_DIV4096;
    endcase
  end

  // =========================================
  // divider counter; clear realigns the period on enable or service
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      preCount <= '0;
      tick <= 1'b0;
    end
    else if (clear)
    begin
      preCount <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (oscTick)
      begin
        if (preCount >= terminal)
        begin
          preCount <= '0;
          tick <= 1'b1;
        end
        else
        begin
          preCount <= preCount + 12'h001;
        end
      end
    end
  end
endmodule

/* rtl/lswdt_sync.sv */
// write-crossing tracker: models a write taking two oscillator ticks to land
// assumes oscTick is a one-cycle enable; start is a one-cycle write pulse
`timescale 1ns/100ps
module lswdt_sync
  import lswdt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  input wire logic oscTick,
  output logic busy,
  output logic landed
);
  import lswdt_pkg::*;

  lswdt_sync_t state;
  logic [1:0] ticks;

  // =========================================
  // busy from write until two oscillator ticks pass
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= SYNC_IDLE;
      ticks <= 2'h0;
      busy <= 1'b0;
      landed <= 1'b0;
    end
    else
    begin
      landed <= 1'b0;
      case (state)
        SYNC_IDLE:
        begin
          if (start)
          begin
            state <= SYNC_WAIT;
            ticks <= 2'h0;
            busy <= 1'b1;
          end
        end
        SYNC_WAIT:
        begin
          if (oscTick)
          begin
            if (ticks == 2'h1)
            begin
              state <= SYNC_DONE;
              landed <= 1'b1;
            end
            ticks <= ticks + 2'h1;
          end
        end
        SYNC_DONE:
        begin
          state <= SYNC_IDLE;
          busy <= 1'b0;
        end
        default:
        begin
          state <= SYNC_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule

/* verif/lswdt_monitor.sv */
// port checker of the lock-and-service watchdog
// assumes it is bound into lswdt_top, one clock and one reset
`timescale 1ns/100ps
// ==========
// checker
module lswdt_monitor
  import lswdt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic oscTick,
  input wire logic shutdown,
  input wire logic wakeFromShutdown,
  input wire logic hibernate,
  input wire logic activeMode,
  input wire logic [lswdt_pkg::ADDR_W-1:0] regAddr,
  input wire logic [lswdt_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [lswdt_pkg::DATA_W-1:0] regRdata,
  input wire logic resetReq,
  input wire logic irqReq
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  logic lockSeen;
  wire logic act = resetReq || irqReq;
  // lock shadow; an enabling write while locked changes nothing, so no lock test needed
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      lockSeen <= 1'b0;
    else if (wakeFromShutdown)
      lockSeen <= 1'b0;
    else if (regWrite && regAddr == ADDR_CONTROL && regWdata[CTL_ENABLE])
      lockSeen <= 1'b1;
  // a tick just before the key could still expire the old period, so it is excluded
  sequence goodKey;
    regWrite && regAddr == ADDR_SERVICE && regWdata == SERVICE_KEY && !$past(oscTick);
  endsequence
  sequence reloadBack;
    regWrite && regAddr == ADDR_RELOAD && !lockSeen ##1 !regWrite
      ##1 regRead && regAddr == ADDR_RELOAD;
  endsequence
  read_idle_a: assert property (!regRead |=> regRdata == 16'h0000)
    else $error("read data outside read slot");
  one_action_a: assert property (!(resetReq && irqReq))
    else $error("reset and interrupt together");
  irq_active_a: assert property (irqReq |-> $past(activeMode))
    else $error("interrupt outside active mode");
  good_key_a: assert property (goodKey |=> !act)
    else $error("service key caused a timeout");
  status_fixed_a: assert property (regRead && regAddr == ADDR_STATUS
    |=> regRdata[15:5] == 11'h001) else $error("status fixed bits wrong");
  control_bit4_a: assert property (regRead && regAddr == ADDR_CONTROL
    |=> !regRdata[4]) else $error("control bit 4 not zero");
  shutdown_quiet_a: assert property (shutdown && $past(shutdown) && !regWrite
    |=> !act) else $error("timeout during shutdown");
  lock_flag_a: assert property (regRead && regAddr == ADDR_STATUS
    |=> regRdata[STA_LOCK] == $past(lockSeen)) else $error("lock flag wrong");
  reload_back_a: assert property (reloadBack |=> regRdata == $past(regWdata, 3))
    else $error("reload read back wrong");
endmodule

bind lswdt_top lswdt_monitor lswdt_monitor_i (.clk_sys(clk_sys), .nrst(nrst),
  .oscTick(oscTick), .shutdown(shutdown), .wakeFromShutdown(wakeFromShutdown),
  .hibernate(hibernate), .activeMode(activeMode), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .resetReq(resetReq),
  .irqReq(irqReq));

/* verif/lswdt_sys_partner.sv */
// model of the system reset logic and interrupt input facing the watchdog
// assumes one-cycle action pulses on clk_sys
`timescale 1ns/100ps
// ==========
// partner
module lswdt_sys_partner
(
  input wire logic clk_sys,
  input wire logic resetReq,
  input wire logic irqReq,
  output int nRst,
  output int nIrq
);
  // tallies survive the watchdog's own reset so the bench can count every action;
  // two-state counters start at zero, so this block is their only driver
  always @(posedge clk_sys)
  begin
    nRst <= nRst + int'(resetReq);
    nIrq <= nIrq + int'(irqReq);
  end
endmodule

/* verif/testbench.sv */
// self-checking bench of the lock-and-service watchdog
// assumes lswdt_top, lswdt_sys_partner and lswdt_monitor are compiled first
`timescale 1ns/100ps
// ==========
// bench
module testbench;
  import lswdt_pkg::*;
  logic clk_sys, nrst, oscTick, shutdown, wakeFromShutdown, hibernate, activeMode;
  logic regWrite, regRead, resetReq, irqReq;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata, rdata;
  int nRst, nIrq, k, sel;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  lswdt_top lswdt_top_i (.clk_sys(clk_sys), .nrst(nrst), .oscTick(oscTick),
    .shutdown(shutdown), .wakeFromShutdown(wakeFromShutdown), .hibernate(hibernate),
    .activeMode(activeMode), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .resetReq(resetReq), .irqReq(irqReq));
  lswdt_sys_partner lswdt_sys_partner_i (.clk_sys(clk_sys), .resetReq(resetReq),
    .irqReq(irqReq), .nRst(nRst), .nIrq(nIrq));
  // 10 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // oscillator tick every fourth cycle, far above the real rate to keep the run short
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    oscTick <= (cyc % 4 == 3);
    if (cyc == 80000)
    begin
      n_mismatch++;
      conclude;
    end
  end
  task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic get(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    // read data stand until this edge; taken before the flop updates, keeping stimulus on edges
    @(posedge clk_sys);
    rdata = regRdata;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, e);
    get(a);
    chk($sformatf("register %h", a), e, rdata & m);
  endtask
  // software waits for the busy bit before touching the register again
  task automatic settle(input int b);
    for (int i = 0; i < 20 && (i == 0 || rdata[b]); i++)
      get(ADDR_STATUS);
    chk("busy bit", 16'h0000, 16'(rdata[b]));
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys iff oscTick);
  endtask
  task automatic doReset;
    nrst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {nrst, shutdown, wakeFromShutdown, hibernate, activeMode, regWrite, regRead} = '0;
    {regAddr, regWdata} = '0;
    doReset;
    rd(ADDR_RELOAD, 16'hFFFF, RST_RELOAD);
    rd(ADDR_COUNT, 16'hFFFF, RST_RELOAD);
    rd(ADDR_CONTROL, 16'hFFFF, RST_CONTROL);
    rd(ADDR_STATUS, 16'hFFFF, STATUS_FIXED);
    rd(32'h40002590, 16'hFFFF, 16'h0000);
    wr(ADDR_CONTROL, 16'h0000);
    rd(ADDR_STATUS, 16'h0008, 16'h0008);
    settle(STA_CON);
    wr(ADDR_RELOAD, 16'h0020);
    rd(ADDR_RELOAD, 16'hFFFF, 16'h0020);
    settle(STA_LD);
    rd(ADDR_COUNT, 16'hFFFF, 16'h0020);
    // every prescale ratio: three divisions after a service take off three counts
    for (sel = 0; sel < 4; sel++)
    begin
      doReset;
      wr(ADDR_RELOAD, 16'h0010);
      settle(STA_LD);
      // bit 4 is written as well; it must read back as zero
      wr(ADDR_CONTROL, 16'(32'h30 + sel * 4));
      settle(STA_CON);
      rd(ADDR_STATUS, 16'h0010, 16'h0010);
      wr(ADDR_SERVICE, SERVICE_KEY);
      ticks(3 << (4 * sel));
      get(ADDR_COUNT);
      chk("count", 16'h0001, 16'(rdata inside {[16'h000C:16'h000E]}));
    end
    wr(ADDR_CONTROL, 16'h0000);
    rd(ADDR_CONTROL, 16'hFFFF, 16'h002C);
    wr(ADDR_RELOAD, 16'h0005);
    rd(ADDR_RELOAD, 16'hFFFF, 16'h0010);
    k = nRst;
    wr(ADDR_SERVICE, 16'h1234);
    get(ADDR_COUNT);
    chk("resets", 16'(k + 1), 16'(nRst));
    // regular service holds off the timeout; silence lets it expire once
    doReset;
    wr(ADDR_RELOAD, 16'h0008);
    settle(STA_LD);
    wr(ADDR_CONTROL, 16'h0020);
    settle(STA_CON);
    k = nRst;
    for (sel = 0; sel < 5; sel++)
    begin
      wr(ADDR_SERVICE, SERVICE_KEY);
      ticks(4);
    end
    settle(STA_SVC);
    chk("resets", 16'(k), 16'(nRst));
    ticks(8);
    chk("resets", 16'(k + 1), 16'(nRst));
    // interrupt option, its pending flag, and the fallback outside active mode
    doReset;
    activeMode <= 1'b1;
    wr(ADDR_CONTROL, 16'h0022);
    settle(STA_CON);
    k = nIrq;
    wr(ADDR_SERVICE, 16'h0000);
    rd(ADDR_STATUS, 16'h0001, 16'h0001);
    chk("interrupts", 16'(k + 1), 16'(nIrq));
    // the bad key is still crossing; software waits before the next service write
    settle(STA_SVC);
    wr(ADDR_SERVICE, SERVICE_KEY);
    settle(STA_SVC);
    rd(ADDR_STATUS, 16'h0001, 16'h0000);
    activeMode <= 1'b0;
    k = nRst;
    wr(ADDR_SERVICE, 16'h0000);
    get(ADDR_COUNT);
    chk("resets", 16'(k + 1), 16'(nRst));
    // hibernate halt, shutdown freeze, then wake restores defaults
    doReset;
    wr(ADDR_CONTROL, 16'h0021);
    settle(STA_CON);
    hibernate <= 1'b1;
    wr(ADDR_SERVICE, SERVICE_KEY);
    ticks(6);
    rd(ADDR_COUNT, 16'hFFFF, RST_RELOAD);
    hibernate <= 1'b0;
    shutdown <= 1'b1;
    ticks(6);
    rd(ADDR_COUNT, 16'hFFFF, RST_RELOAD);
    shutdown <= 1'b0;
    wakeFromShutdown <= 1'b1;
    @(posedge clk_sys);
    wakeFromShutdown <= 1'b0;
    rd(ADDR_CONTROL, 16'hFFFF, RST_CONTROL);
    rd(ADDR_STATUS, 16'h0010, 16'h0000);
    conclude;
  end
endmodule
